// ---- shared/stepper_ctrl_pkg.sv ----
// Constants shared by the stepper idle, tune and fault controller
package stepper_ctrl_pkg;
  // Clock rate in kHz
  localparam int unsigned CLK_KHZ = 40000;
  // One second window, in ms
  localparam int unsigned ONE_SEC_MS = 1000;
  localparam int unsigned ONE_SEC_CYC = ONE_SEC_MS * CLK_KHZ;
  // Least input timing, in ns, and cycles rounded up
  localparam int unsigned EN_SETUP_NS = 5000;
  localparam int unsigned DIR_SETUP_NS = 5000;
  localparam int unsigned STEP_HIGH_NS = 2500;
  localparam int unsigned STEP_LOW_NS = 2500;
  localparam int unsigned EN_SETUP_CYC = (EN_SETUP_NS * CLK_KHZ + 999999) / 1000000;
  localparam int unsigned DIR_SETUP_CYC = (DIR_SETUP_NS * CLK_KHZ + 999999) / 1000000;
  localparam int unsigned STEP_HIGH_CYC = (STEP_HIGH_NS * CLK_KHZ + 999999) / 1000000;
  localparam int unsigned STEP_LOW_CYC = (STEP_LOW_NS * CLK_KHZ + 999999) / 1000000;
  // Timing check counters saturate here
  localparam int unsigned CHK_W = 8;
  localparam logic [CHK_W-1:0] CHK_MAX = 8'hff;
  // Setpoint width, milliamps
  localparam int unsigned MA_W = 13;
  // Register word indices on the bus
  localparam int unsigned ADDR_W = 3;
  localparam logic [ADDR_W-1:0] REG_STATUS = 3'h0;
  localparam logic [ADDR_W-1:0] REG_EVENT = 3'h1;
  localparam logic [ADDR_W-1:0] REG_MASK = 3'h2;
  localparam logic [ADDR_W-1:0] REG_SETPOINT = 3'h3;
  // Event bit positions
  localparam int unsigned EV_W = 6;
  localparam int unsigned EV_OV = 0;
  localparam int unsigned EV_OC = 1;
  localparam int unsigned EV_SC = 2;
  localparam int unsigned EV_TSTART = 3;
  localparam int unsigned EV_TDONE = 4;
  localparam int unsigned EV_TIMING = 5;
  // Status bit positions
  localparam int unsigned ST_REDUCED = 3;
  localparam int unsigned ST_TUNING = 4;
  localparam int unsigned ST_ENERGY = 5;
  localparam int unsigned ST_SEL = 6;
  localparam logic [EV_W-1:0] MASK_RST = 6'h00;
  // Tuning sequence states
  typedef enum logic [1:0] {TUNE_WAIT, TUNE_FIRST, TUNE_RUN} tune_t;
endpackage

// ---- design/stepper_idle_tune_fault_ctrl.sv ----
// Idle current, auto-tune trigger, input timing check and fault latch
//
// Overview of operation
// - Three switch bits pick one of eight dynamic currents, 2.00A to 6.00A.
// - Idle switch off halves standstill current; on keeps full dynamic current.
// - With reduction selected, setpoint halves one second after last step.
// - Two idle switch toggles within one second start motor identification.
// - Identification done loads current-loop parameters automatically.
// - Supply above 94V latches over-voltage fault, indicator red.
// - Continuous phase current over limit latches over-current fault.
// - Coil short or coil-to-ground short latches short-circuit fault.
// - Any fault de-energises the motor and drives indicator red.
// - Faults stay latched until power-on reset.
`timescale 1ns/1ps
module stepper_idle_tune_fault_ctrl #(
  parameter int unsigned ONE_SEC_CYCLES = stepper_ctrl_pkg::ONE_SEC_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [2:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic current_select_bit0_i,
  input wire logic current_select_bit1_i,
  input wire logic current_select_bit2_i,
  input wire logic idle_level_switch_i,
  input wire logic step_strobe_input_i,
  input wire logic direction_i,
  input wire logic drive_allow_input_i,
  input wire logic over_voltage_i,
  input wire logic over_current_i,
  input wire logic short_circuit_i,
  input wire logic tune_done_i,
  output logic [stepper_ctrl_pkg::MA_W-1:0] current_setpoint_o,
  output logic motor_energise_o,
  output logic led_red_o,
  output logic step_accept_o,
  output logic tune_start_o,
  output logic tune_busy_o,
  output logic param_load_o,
  output logic irq_o
);
  localparam int CW = $clog2(ONE_SEC_CYCLES + 1);
  localparam logic [CW-1:0] SEC_LAST = CW'(ONE_SEC_CYCLES - 1);
  localparam int unsigned MW = stepper_ctrl_pkg::MA_W;
  localparam int unsigned EW = stepper_ctrl_pkg::EV_W;
  localparam int unsigned KW = stepper_ctrl_pkg::CHK_W;

  // Refuse windows the counters cannot serve
  if (ONE_SEC_CYCLES < 2) begin : g_chk
    $error("ONE_SEC_CYCLES must be at least 2");
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  // Dynamic current table in mA
  function automatic logic [MW-1:0] dyn_ma(input logic [2:0] idx);
    case (idx)
      3'h0: dyn_ma = 13'h07d0;
      3'h1: dyn_ma = 13'h0a0a;
      3'h2: dyn_ma = 13'h0c44;
      3'h3: dyn_ma = 13'h0e7e;
      3'h4: dyn_ma = 13'h10b8;
      3'h5: dyn_ma = 13'h12fc;
      3'h6: dyn_ma = 13'h1536;
      default: dyn_ma = 13'h1770;
    endcase
  endfunction

  // Two-flop synchronisers for all pins except the bus and tune_done_i
  logic [9:0] pin_meta, pin_sync, pin_prev;
  logic [2:0] primed;
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      pin_meta <= 10'h000;
      pin_sync <= 10'h000;
      pin_prev <= 10'h000;
      primed <= 3'h0;
    end else begin
      pin_meta <= {current_select_bit2_i, current_select_bit1_i, current_select_bit0_i,
                   short_circuit_i, over_current_i, over_voltage_i, direction_i,
                   drive_allow_input_i, step_strobe_input_i, idle_level_switch_i};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
      primed <= {primed[1:0], 1'b1};
    end
  end

  logic idle_sw, step_s, allow_s, dir_s, step_rise, step_fall, dir_chg, allow_chg, sw_chg;
  logic edge_ok, timing_err;
  logic [2:0] sel_idx;
  assign idle_sw = pin_sync[0];
  assign step_s = pin_sync[1];
  assign allow_s = pin_sync[2];
  assign dir_s = pin_sync[3];
  // Switch ON reads as 1; all ON is the lowest current
  assign sel_idx = ~pin_sync[9:7];
  // No edges until the pipeline holds real samples, else reset fakes a toggle
  assign edge_ok = primed[2];
  assign step_rise = edge_ok & step_s & ~pin_prev[1];
  assign step_fall = edge_ok & ~step_s & pin_prev[1];
  assign allow_chg = edge_ok & (allow_s ^ pin_prev[2]);
  assign dir_chg = edge_ok & (dir_s ^ pin_prev[3]);
  assign sw_chg = edge_ok & (idle_sw ^ pin_prev[0]);
  // Input timing check counters
  logic [KW-1:0] hi_cnt, lo_cnt, dir_cnt, en_cnt;
  logic [KW-1:0] next_hi_cnt, next_lo_cnt, next_dir_cnt, next_en_cnt;
  function automatic logic [KW-1:0] sat_inc(input logic [KW-1:0] v);
    sat_inc = (v == stepper_ctrl_pkg::CHK_MAX) ? v : v + 8'h01;
  endfunction
  always_comb begin
    next_hi_cnt = step_rise ? '0 : sat_inc(hi_cnt);
    next_lo_cnt = step_fall ? '0 : sat_inc(lo_cnt);
    next_dir_cnt = dir_chg ? '0 : sat_inc(dir_cnt);
    next_en_cnt = allow_chg ? '0 : sat_inc(en_cnt);
    timing_err = (dir_chg && en_cnt < KW'(stepper_ctrl_pkg::EN_SETUP_CYC)) ||
                 (step_rise && dir_cnt < KW'(stepper_ctrl_pkg::DIR_SETUP_CYC)) ||
                 (step_fall && hi_cnt < KW'(stepper_ctrl_pkg::STEP_HIGH_CYC)) ||
                 (step_rise && lo_cnt < KW'(stepper_ctrl_pkg::STEP_LOW_CYC));
  end
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      hi_cnt <= stepper_ctrl_pkg::CHK_MAX;
      lo_cnt <= stepper_ctrl_pkg::CHK_MAX;
      dir_cnt <= stepper_ctrl_pkg::CHK_MAX;
      en_cnt <= stepper_ctrl_pkg::CHK_MAX;
    end else begin
      hi_cnt <= next_hi_cnt;
      lo_cnt <= next_lo_cnt;
      dir_cnt <= next_dir_cnt;
      en_cnt <= next_en_cnt;
    end
  end

  // Fault latches, cleared only by power-on reset
  logic fault_ov, fault_oc, fault_sc, fault_any, next_fault_ov, next_fault_oc, next_fault_sc;
  always_comb begin
    next_fault_ov = fault_ov | pin_sync[4];
    next_fault_oc = fault_oc | pin_sync[5];
    next_fault_sc = fault_sc | pin_sync[6];
  end
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      fault_ov <= 1'b0;
      fault_oc <= 1'b0;
      fault_sc <= 1'b0;
    end else begin
      fault_ov <= next_fault_ov;
      fault_oc <= next_fault_oc;
      fault_sc <= next_fault_sc;
    end
  end
  assign fault_any = fault_ov | fault_oc | fault_sc;

  // Tune sequence state
  stepper_ctrl_pkg::tune_t tune_state, next_tune_state;
  logic [CW-1:0] win_cnt, next_win_cnt;
  logic next_tune_start, next_param_load, step_ok;
  // steps during identification are not taken
  assign step_ok = step_rise & allow_s & ~fault_any &
                   (tune_state != stepper_ctrl_pkg::TUNE_RUN);
  always_comb begin
    next_tune_state = tune_state;
    next_win_cnt = win_cnt;
    next_tune_start = 1'b0;
    next_param_load = 1'b0;
    case (tune_state)
      stepper_ctrl_pkg::TUNE_WAIT: begin
        if (sw_chg && !fault_any) begin
          next_tune_state = stepper_ctrl_pkg::TUNE_FIRST;
          next_win_cnt = '0;
        end
      end
      stepper_ctrl_pkg::TUNE_FIRST: begin
        if (step_rise || fault_any) begin
          next_tune_state = stepper_ctrl_pkg::TUNE_WAIT;
        end else if (sw_chg) begin
          next_tune_state = stepper_ctrl_pkg::TUNE_RUN;
          next_tune_start = 1'b1;
        end else if (win_cnt == SEC_LAST) begin
          next_tune_state = stepper_ctrl_pkg::TUNE_WAIT;
        end else begin
          next_win_cnt = win_cnt + 1'b1;
        end
      end
      stepper_ctrl_pkg::TUNE_RUN: begin
        if (fault_any) begin
          next_tune_state = stepper_ctrl_pkg::TUNE_WAIT;
        end else if (tune_done_i) begin
          next_tune_state = stepper_ctrl_pkg::TUNE_WAIT;
          next_param_load = 1'b1;
        end
      end
      default: next_tune_state = stepper_ctrl_pkg::TUNE_WAIT;
    endcase
  end
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      tune_state <= stepper_ctrl_pkg::TUNE_WAIT;
      win_cnt <= '0;
      tune_start_o <= 1'b0;
      param_load_o <= 1'b0;
    end else begin
      tune_state <= next_tune_state;
      win_cnt <= next_win_cnt;
      tune_start_o <= next_tune_start;
      param_load_o <= next_param_load;
    end
  end

  // Idle timer and current setpoint
  logic [CW-1:0] idle_cnt, next_idle_cnt;
  logic idle_reached, next_idle_reached, next_energise, next_red, next_busy;
  logic [MW-1:0] dyn, next_setpoint;
  assign dyn = dyn_ma(sel_idx);
  always_comb begin
    next_idle_cnt = idle_cnt;
    next_idle_reached = idle_reached;
    if (step_ok) begin
      next_idle_cnt = '0;
      next_idle_reached = 1'b0;
    end else if (!idle_reached) begin
      next_idle_cnt = idle_cnt + 1'b1;
      next_idle_reached = (idle_cnt == SEC_LAST);
    end
    next_setpoint = dyn;
    if (fault_any) begin
      next_setpoint = '0;
    end else if (!idle_sw && idle_reached) begin
      next_setpoint = dyn >> 1;
    end
    next_energise = ~fault_any & allow_s;
    next_red = fault_any;
    next_busy = (tune_state == stepper_ctrl_pkg::TUNE_RUN);
  end
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      idle_cnt <= '0;
      idle_reached <= 1'b0;
      current_setpoint_o <= '0;
      motor_energise_o <= 1'b0;
      led_red_o <= 1'b0;
      step_accept_o <= 1'b0;
      tune_busy_o <= 1'b0;
    end else begin
      idle_cnt <= next_idle_cnt;
      idle_reached <= next_idle_reached;
      current_setpoint_o <= next_setpoint;
      motor_energise_o <= next_energise;
      led_red_o <= next_red;
      step_accept_o <= step_ok;
      tune_busy_o <= next_busy;
    end
  end

  // Bus slave, sticky events and interrupt
  logic [EW-1:0] events, next_events, ev_in, mask, next_mask;
  logic [31:0] next_rdata, status_word;
  logic next_wait, next_irq, take, ev_clr;
  assign take = ~avs_waitrequest_o & (avs_read_i | avs_write_i);
  assign ev_clr = take & avs_read_i & (avs_address_i == stepper_ctrl_pkg::REG_EVENT);
  always_comb begin
    ev_in = '0;
    ev_in[stepper_ctrl_pkg::EV_OV] = next_fault_ov & ~fault_ov;
    ev_in[stepper_ctrl_pkg::EV_OC] = next_fault_oc & ~fault_oc;
    ev_in[stepper_ctrl_pkg::EV_SC] = next_fault_sc & ~fault_sc;
    ev_in[stepper_ctrl_pkg::EV_TSTART] = next_tune_start;
    ev_in[stepper_ctrl_pkg::EV_TDONE] = next_param_load;
    ev_in[stepper_ctrl_pkg::EV_TIMING] = timing_err;
    // Read clears only the bits it returned, so a late event survives; set wins
    next_events = (events & ~({EW{ev_clr}} & avs_readdata_o[EW-1:0])) | ev_in;
    next_mask = mask;
    if (take && avs_write_i && avs_address_i == stepper_ctrl_pkg::REG_MASK) begin
      next_mask = avs_writedata_i[EW-1:0];
    end
    next_irq = |(next_events & next_mask);
    status_word = '0;
    status_word[2:0] = {fault_sc, fault_oc, fault_ov};
    status_word[stepper_ctrl_pkg::ST_REDUCED] = ~idle_sw & idle_reached;
    status_word[stepper_ctrl_pkg::ST_TUNING] = tune_busy_o;
    status_word[stepper_ctrl_pkg::ST_ENERGY] = motor_energise_o;
    status_word[stepper_ctrl_pkg::ST_SEL +: 3] = sel_idx;
    case (avs_address_i)
      stepper_ctrl_pkg::REG_STATUS: next_rdata = status_word;
      stepper_ctrl_pkg::REG_EVENT: next_rdata = {{(32-EW){1'b0}}, events};
      stepper_ctrl_pkg::REG_MASK: next_rdata = {{(32-EW){1'b0}}, mask};
      stepper_ctrl_pkg::REG_SETPOINT: next_rdata = {{(32-MW){1'b0}}, current_setpoint_o};
      default: next_rdata = '0;
    endcase
    // One wait cycle, then a single low cycle
    next_wait = ~(avs_waitrequest_o & (avs_read_i | avs_write_i));
  end
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      events <= '0;
      mask <= stepper_ctrl_pkg::MASK_RST;
      irq_o <= 1'b0;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= '0;
    end else begin
      events <= next_events;
      mask <= next_mask;
      irq_o <= next_irq;
      avs_waitrequest_o <= next_wait;
      if (avs_waitrequest_o) begin
        avs_readdata_o <= next_rdata;
      end
    end
  end

  // Checks next to the logic
  fault_hold_a: assert property (fault_any |=> fault_any ##1 fault_any)
    else $error("fault latch dropped");
  dead_on_fault_a: assert property (fault_any |=> !motor_energise_o && led_red_o)
    else $error("motor energised during fault");
  ov_latch_a: assert property (pin_sync[4] |=> fault_ov ##1 led_red_o)
    else $error("over-voltage not latched");
  oc_latch_a: assert property (pin_sync[5] |=> fault_oc ##1 current_setpoint_o == '0)
    else $error("over-current not latched");
  sc_latch_a: assert property (pin_sync[6] |=> fault_sc ##1 !motor_energise_o)
    else $error("short circuit not latched");
  idle_half_a: assert property (!idle_sw && idle_reached && !fault_any
    |=> current_setpoint_o == ($past(dyn) >> 1))
    else $error("standstill current not halved");
  full_still_a: assert property (idle_sw && !fault_any
    |=> current_setpoint_o == $past(dyn))
    else $error("full standstill current lost");
  step_restart_a: assert property (step_ok |=> idle_cnt == '0 && !idle_reached
    ##1 !idle_reached)
    else $error("idle timer not restarted");
  tune_start_a: assert property (tune_state == stepper_ctrl_pkg::TUNE_FIRST && sw_chg
    && !step_rise && !fault_any |=> tune_start_o ##1 !tune_start_o)
    else $error("tune start missed");
  tune_cancel_a: assert property (tune_state == stepper_ctrl_pkg::TUNE_FIRST && step_rise
    |=> tune_state == stepper_ctrl_pkg::TUNE_WAIT)
    else $error("tune window not cancelled");
  param_load_a: assert property (tune_state == stepper_ctrl_pkg::TUNE_RUN && tune_done_i
    && !fault_any |=> param_load_o ##1 !param_load_o)
    else $error("loop parameters not loaded");
  step_width_a: assert property (step_fall
    && hi_cnt < KW'(stepper_ctrl_pkg::STEP_HIGH_CYC) |=> events[stepper_ctrl_pkg::EV_TIMING])
    else $error("short step not flagged");
  bus_ack_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer not one cycle");
endmodule

// ---- testbench/step_source.sv ----
// Motion controller model driving enable, direction and step pulses
`timescale 1ns/1ps
module step_source #(
  parameter int unsigned ALLOW_CYC = stepper_ctrl_pkg::EN_SETUP_CYC + 4,
  parameter int unsigned SETUP_CYC = stepper_ctrl_pkg::DIR_SETUP_CYC + 4,
  parameter int unsigned LOW_CYC = stepper_ctrl_pkg::STEP_LOW_CYC + 4
) (
  input wire logic ref_clk_i,
  output logic step_o,
  output logic dir_o,
  output logic allow_o
);
  // Lines rest low until commanded
  initial begin
    step_o = 1'b0;
    dir_o = 1'b0;
    allow_o = 1'b0;
  end

  task automatic set_allow(input logic v);
    allow_o <= v;
    repeat (ALLOW_CYC) @(posedge ref_clk_i);
  endtask

  task automatic send_step(input logic d, input int unsigned high_cyc);
    dir_o <= d;
    repeat (SETUP_CYC) @(posedge ref_clk_i);
    step_o <= 1'b1;
    repeat (high_cyc) @(posedge ref_clk_i);
    step_o <= 1'b0;
    repeat (LOW_CYC) @(posedge ref_clk_i);
  endtask
endmodule

// ---- testbench/tb.sv ----
// Self-checking bench for the stepper idle, tune and fault controller
`timescale 1ns/1ps
module tb;
  localparam int unsigned ONE_SEC = 50;
  localparam int unsigned HIGH_OK = stepper_ctrl_pkg::STEP_HIGH_CYC + 4;
  localparam logic [12:0] AMPS [8] = '{13'h7d0, 13'ha0a, 13'hc44, 13'he7e,
                                       13'h10b8, 13'h12fc, 13'h1536, 13'h1770};
  logic ref_clk_i;
  logic rstn_i;
  logic [2:0] avs_address_i;
  logic avs_read_i;
  logic avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [2:0] sel;
  logic idle_sw;
  logic step_w;
  logic dir_w;
  logic allow_w;
  logic [2:0] fault;
  logic tune_done_i;
  logic [stepper_ctrl_pkg::MA_W-1:0] current_setpoint_o;
  logic motor_energise_o;
  logic led_red_o;
  logic step_accept_o;
  logic tune_start_o;
  logic tune_busy_o;
  logic param_load_o;
  logic irq_o;
  logic [31:0] rd;
  logic seen;
  int mismatches;
  int samples_checked;

  // Free-running 40 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  stepper_idle_tune_fault_ctrl #(.ONE_SEC_CYCLES(ONE_SEC)) stepper_idle_tune_fault_ctrl_i (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .current_select_bit0_i(sel[0]), .current_select_bit1_i(sel[1]),
    .current_select_bit2_i(sel[2]), .idle_level_switch_i(idle_sw),
    .step_strobe_input_i(step_w), .direction_i(dir_w), .drive_allow_input_i(allow_w),
    .over_voltage_i(fault[0]), .over_current_i(fault[1]), .short_circuit_i(fault[2]),
    .tune_done_i(tune_done_i), .current_setpoint_o(current_setpoint_o),
    .motor_energise_o(motor_energise_o), .led_red_o(led_red_o),
    .step_accept_o(step_accept_o), .tune_start_o(tune_start_o), .tune_busy_o(tune_busy_o),
    .param_load_o(param_load_o), .irq_o(irq_o));

  step_source step_source_i (.ref_clk_i(ref_clk_i), .step_o(step_w), .dir_o(dir_w),
    .allow_o(allow_w));

  // Verdict and end of run
  task automatic complete_run();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= wd;
    avs_read_i <= ~wr;
    avs_write_i <= wr;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    if (avs_waitrequest_o !== 1'b0) begin
      mismatches++;
      $display("Error t=%0t bus timeout", $time);
      complete_run();
    end
    @(posedge ref_clk_i);
  endtask

  // Bounded wait for a one-cycle output pulse
  task automatic wait_for(input int which, input int lim, output logic hit);
    int n;
    hit = 1'b0;
    for (n = 0; n < lim && !hit; n++) begin
      @(posedge ref_clk_i);
      case (which)
        0: hit = (step_accept_o === 1'b1);
        1: hit = (tune_start_o === 1'b1);
        default: hit = (param_load_o === 1'b1);
      endcase
    end
  endtask

  task automatic expect_pulse(input int which, input int lim);
    logic hit;
    wait_for(which, lim, hit);
    if (!hit) begin
      mismatches++;
      $display("Error t=%0t pulse %0d missing", $time, which);
      complete_run();
    end
  endtask

  // Main sequence
  initial begin
    rstn_i = 1'b0;
    avs_address_i = 3'h0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    sel = 3'h0;
    idle_sw = 1'b1;
    fault = 3'h0;
    tune_done_i = 1'b0;
    mismatches = 0;
    samples_checked = 0;
    cyc(8);
    rstn_i <= 1'b1;
    cyc(1);
    chk(avs_waitrequest_o, 1'b1, "wait at rest");
    bus(1'b0, stepper_ctrl_pkg::REG_MASK, 32'h0);
    chk(rd, 32'h0, "mask reset");
    bus(1'b1, stepper_ctrl_pkg::REG_MASK, 32'hffffffff);
    bus(1'b0, stepper_ctrl_pkg::REG_MASK, 32'h0);
    chk(rd, 32'h3f, "mask rw");
    bus(1'b1, stepper_ctrl_pkg::REG_SETPOINT, 32'h0);
    bus(1'b0, 3'h5, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    step_source_i.set_allow(1'b1);
    chk(motor_energise_o, 1'b1, "energised");
    // Every switch code, full standstill level
    for (int k = 0; k < 8; k++) begin
      sel <= 3'(~k);
      cyc(6);
      chk(current_setpoint_o, AMPS[k], "dynamic current");
      bus(1'b0, stepper_ctrl_pkg::REG_SETPOINT, 32'h0);
      chk(rd, 32'(AMPS[k]), "setpoint reg");
    end
    for (int s = 1; s >= 0; s--) begin
      idle_sw <= s[0];
      cyc(60);
      idle_sw <= ~s[0];
      cyc(10);
      idle_sw <= s[0];
      expect_pulse(1, 20);
      cyc(2);
      chk(tune_busy_o, 1'b1, "tune busy");
      chk(irq_o, 1'b1, "irq on tune");
      tune_done_i <= 1'b1;
      cyc(1);
      tune_done_i <= 1'b0;
      expect_pulse(2, 5);
      cyc(2);
      chk(tune_busy_o, 1'b0, "tune ended");
      bus(1'b0, stepper_ctrl_pkg::REG_EVENT, 32'h0);
      chk(rd & 32'h18, 32'h18, "tune events");
      cyc(2);
      chk(irq_o, 1'b0, "irq cleared");
    end
    // Second toggle after the window closes
    idle_sw <= 1'b1;
    cyc(70);
    idle_sw <= 1'b0;
    wait_for(1, 20, seen);
    chk(seen, 1'b0, "late toggle");
    cyc(60);
    chk(current_setpoint_o, 13'hbb8, "standstill half");
    bus(1'b0, stepper_ctrl_pkg::REG_STATUS, 32'h0);
    chk(rd, 32'h1e8, "status word");
    fork
      step_source_i.send_step(1'b1, HIGH_OK);
      begin
        expect_pulse(0, 400);
        cyc(3);
        chk(current_setpoint_o, 13'h1770, "full on step");
        cyc(40);
        chk(current_setpoint_o, 13'h1770, "full in second");
        cyc(20);
        chk(current_setpoint_o, 13'hbb8, "reduced");
      end
    join
    // Step inside an open tune window cancels it
    fork
      step_source_i.send_step(1'b1, HIGH_OK);
      begin
        cyc(190);
        idle_sw <= 1'b1;
        cyc(30);
        idle_sw <= 1'b0;
        wait_for(1, 20, seen);
        chk(seen, 1'b0, "tune cancelled");
      end
    join
    // Short pulse flagged, masked then unmasked
    bus(1'b1, stepper_ctrl_pkg::REG_MASK, 32'h0);
    step_source_i.send_step(1'b0, 10);
    chk(irq_o, 1'b0, "masked irq");
    bus(1'b1, stepper_ctrl_pkg::REG_MASK, 32'h20);
    cyc(2);
    chk(irq_o, 1'b1, "unmasked irq");
    bus(1'b0, stepper_ctrl_pkg::REG_EVENT, 32'h0);
    chk(rd & 32'h20, 32'h20, "timing event");
    // Each fault latches until reset
    for (int f = 0; f < 3; f++) begin
      fault <= 3'(1 << f);
      cyc(5);
      fault <= 3'h0;
      cyc(5);
      chk(led_red_o, 1'b1, "fault led");
      chk(motor_energise_o, 1'b0, "fault power off");
      chk(current_setpoint_o, 13'h0, "fault setpoint");
      bus(1'b0, stepper_ctrl_pkg::REG_EVENT, 32'h0);
      chk(rd & 32'h7, 32'(1 << f), "fault event");
      bus(1'b0, stepper_ctrl_pkg::REG_STATUS, 32'h0);
      chk(rd & 32'h7, 32'(1 << f), "fault status");
      fork
        step_source_i.send_step(1'b1, HIGH_OK);
        begin
          wait_for(0, 300, seen);
          chk(seen, 1'b0, "step refused");
        end
      join
      chk(led_red_o, 1'b1, "fault held");
      rstn_i <= 1'b0;
      cyc(8);
      rstn_i <= 1'b1;
      cyc(6);
      chk(led_red_o, 1'b0, "fault cleared");
      chk(motor_energise_o, 1'b1, "power back");
    end
    complete_run();
  end
endmodule
